// ---- tsrc_pkg.sv ----
// Package for the triple square-wave rate clock block.
// Assumes one 25 MHz system clock and an APB register interface.
`default_nettype none
package tsrc_pkg;
  // Register byte offsets (control port pointer model kept as index, APB word per register).
  localparam logic [7:0] TSRC_OFF_CTRL    = 8'h00;
  localparam logic [7:0] TSRC_OFF_PTR     = 8'h04;
  localparam logic [7:0] TSRC_OFF_DATA    = 8'h08;
  localparam logic [7:0] TSRC_OFF_STATUS  = 8'h0C;
  // Internal register indices reached through the pointer.
  localparam logic [5:0] TSRC_IDX_MASTER  = 6'h00;
  localparam logic [5:0] TSRC_IDX_MODE0   = 6'h1C;
  localparam logic [5:0] TSRC_IDX_CMD0    = 6'h0A;
  localparam logic [5:0] TSRC_IDX_TCMSB0  = 6'h16;
  // Command register bit positions.
  localparam int TSRC_CMD_GATE_BIT = 2;
  localparam int TSRC_CMD_TRIG_BIT = 1;
  // Mode register bits: continuous, external output enable and square wave.
  localparam int TSRC_MODE_CONT_BIT = 7;
  localparam int TSRC_MODE_EOE_BIT  = 6;
  localparam int TSRC_MODE_SQW_BIT  = 1;
  // Reset values.
  localparam logic [15:0] TSRC_TC_RESET   = 16'h0000;
  localparam logic [7:0]  TSRC_MODE_RESET = 8'h00;

  // Access machine state.
  typedef enum logic [0:0]
  {
    TSRC_ST_POINTER = 1'b0,
    TSRC_ST_ACCESS  = 1'b1
  } tsrc_state_type;

  // Per-channel control bundle.
  typedef struct packed
  {
    logic [15:0] timeConst;
    logic        continuous;
    logic        outEnable;
    logic        squareWave;
    logic        gate;
    logic        trigger;
  } tsrc_chan_type;
endpackage
`default_nettype wire

// ---- tsrc_counter.sv ----
// One 16-bit square-wave down-counter channel.
// Assumes countTick is a one-cycle pulse at half the source clock rate.
`timescale 1ns/100ps
`default_nettype none
module tsrc_counter
  import tsrc_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Control
  input  wire tsrc_chan_type    ctl,
  input  wire logic             countTick,
  // Result
  output logic                  wave,
  output logic [WIDTH-1:0]      count
);
  logic running;

  // Trigger loads the constant; the gate holds count and level while low.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count   <= '0;
      wave    <= 1'b0;
      running <= 1'b0;
    end
    else if (ctl.trigger)
    begin
      count   <= ctl.timeConst[WIDTH-1:0];
      wave    <= 1'b1;
      running <= 1'b1;
    end
    else if (running && ctl.gate && countTick)
    begin
      if (count <= 1)
      begin
        // Each level lasts one full count-down, so a cycle is twice the constant.
        count <= ctl.timeConst[WIDTH-1:0];
        if (ctl.squareWave)
          wave <= ~wave;
        running <= ctl.continuous;
      end
      else
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tsrc_top.sv ----
// Three square-wave rate clock channels with an APB pointer-style control port.
// Assumes srcClk is sampled synchronously; it need not relate to the bus host.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tsrc_top
  import tsrc_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Counter source clock level
  input  wire logic        srcClk,
  // Port pins
  output logic [7:0]       portBOut,
  output logic [7:0]       portBOe,
  output logic [3:0]       portCOut,
  output logic [3:0]       portCOe
);
  tsrc_state_type state;
  logic           resetLatch;
  logic [5:0]     pointer;
  logic [7:0]     masterCfg;
  logic [7:0]     modeReg [3];
  logic [15:0]    tcReg   [3];
  logic [2:0]     gateBit;
  logic [2:0]     trigPulse;
  logic           srcPrev;
  logic           halfClk;
  logic           countTick;
  logic [2:0]     waves;
  logic [15:0]    counts [3];
  logic           access;
  logic           wrData;
  logic [7:0]     dataByte;
  logic [7:0]     readByte;

  assign access   = psel && penable;
  assign pready   = 1'b1;
  assign wrData   = access && pwrite;
  assign dataByte = pwdata[7:0];

  // Unmapped addresses answer with an error; every slot is word aligned.
  assign pslverr = access && (paddr != TSRC_OFF_CTRL) && (paddr != TSRC_OFF_PTR)
                   && (paddr != TSRC_OFF_DATA) && (paddr != TSRC_OFF_STATUS);

  // Halve the source clock; the edge of srcClk toggles halfClk.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      srcPrev <= 1'b0;
      halfClk <= 1'b0;
    end
    else
    begin
      srcPrev <= srcClk;
      if (srcClk && !srcPrev)
        halfClk <= ~halfClk;
    end
  end

  // One tick per halved period with no further prescaling.
  assign countTick = srcClk && !srcPrev && halfClk;

  // Pointer machine on the control port; pointer write then one access.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state   <= TSRC_ST_POINTER;
      pointer <= '0;
    end
    else if (access && paddr == TSRC_OFF_CTRL)
    begin
      if (state == TSRC_ST_POINTER && pwrite)
      begin
        pointer <= dataByte[5:0];
        state   <= TSRC_ST_ACCESS;
      end
      else
      begin
        state <= TSRC_ST_POINTER;
      end
    end
    else if (access && paddr == TSRC_OFF_PTR && pwrite)
    begin
      pointer <= dataByte[5:0];
    end
  end

  // Register writes by pointer, blocked while the reset latch is set, except the latch bit of the master register.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      resetLatch <= 1'b1;
      masterCfg  <= 8'h00;
      gateBit    <= '0;
      trigPulse  <= '0;
      for (int i = 0; i < 3; i++)
      begin
        modeReg[i] <= TSRC_MODE_RESET;
        tcReg[i]   <= TSRC_TC_RESET;
      end
    end
    else
    begin
      trigPulse <= '0;
      if ((wrData && paddr == TSRC_OFF_CTRL && state == TSRC_ST_ACCESS) || (wrData && paddr == TSRC_OFF_DATA))
      begin
        if (pointer == TSRC_IDX_MASTER)
        begin
          resetLatch <= dataByte[0];
          if (!resetLatch)
            masterCfg <= dataByte;
        end
        else if (!resetLatch)
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (pointer == TSRC_IDX_MODE0 + 6'(i))
              modeReg[i] <= dataByte;
            if (pointer == TSRC_IDX_TCMSB0 + 6'(2 * i))
              tcReg[i][15:8] <= dataByte;
            if (pointer == TSRC_IDX_TCMSB0 + 6'(2 * i + 1))
              tcReg[i][7:0] <= dataByte;
            if (pointer == TSRC_IDX_CMD0 + 6'(i))
            begin
              gateBit[i]   <= dataByte[TSRC_CMD_GATE_BIT];
              trigPulse[i] <= dataByte[TSRC_CMD_TRIG_BIT];
            end
          end
        end
      end
    end
  end

  // Read mux for the pointed register.
  always_comb
  begin
    readByte = 8'h00;
    if (pointer == TSRC_IDX_MASTER)
      readByte = {masterCfg[7:1], resetLatch};
    for (int i = 0; i < 3; i++)
    begin
      if (pointer == TSRC_IDX_MODE0 + 6'(i))
        readByte = modeReg[i];
      if (pointer == TSRC_IDX_TCMSB0 + 6'(2 * i))
        readByte = counts[i][15:8];
      if (pointer == TSRC_IDX_TCMSB0 + 6'(2 * i + 1))
        readByte = counts[i][7:0];
      if (pointer == TSRC_IDX_CMD0 + 6'(i))
        readByte = {5'h00, gateBit[i], 1'b0, waves[i]};
    end
  end

  // Read data is registered ahead of the access phase.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && paddr == TSRC_OFF_STATUS)
      prdata <= {22'h000000, state, resetLatch, 5'h00, waves};
    else if (psel && !penable && paddr == TSRC_OFF_PTR)
      prdata <= {26'h0000000, pointer};
    else if (psel && !penable)
      prdata <= {24'h000000, readByte};
  end

  // Three channels built from one counter module.
  for (genvar g = 0; g < 3; g++)
  begin : gChan
    tsrc_chan_type ctl;
    assign ctl.timeConst  = tcReg[g];
    assign ctl.continuous = modeReg[g][TSRC_MODE_CONT_BIT];
    assign ctl.outEnable  = modeReg[g][TSRC_MODE_EOE_BIT];
    assign ctl.squareWave = modeReg[g][TSRC_MODE_SQW_BIT];
    assign ctl.gate       = gateBit[g];
    assign ctl.trigger    = trigPulse[g];
    tsrc_counter #(.WIDTH(WIDTH)) uCnt
    (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .ctl       (ctl),
      .countTick (countTick),
      .wave      (waves[g]),
      .count     (counts[g])
    );
  end

  // Output pins: channel 1 on B4, 2 on B0, 3 on C0; all other bits are inputs.
  assign portBOut = {3'b000, waves[0], 3'b000, waves[1]};
  assign portBOe  = {3'b000, modeReg[0][TSRC_MODE_EOE_BIT], 3'b000, modeReg[1][TSRC_MODE_EOE_BIT]};
  assign portCOut = {3'b000, waves[2]};
  assign portCOe  = {3'b000, modeReg[2][TSRC_MODE_EOE_BIT]};
endmodule
`default_nettype wire

// ---- tsrc_props.sv ----
// Checker on the ports of the rate clock block.
// Assumes the bench may stall srcClk for tens of cycles.
`timescale 1ns/100ps
`default_nettype none
module tsrc_props
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Source clock and pins
  input wire logic        srcClk,
  input wire logic [7:0]  portBOut,
  input wire logic [7:0]  portBOe,
  input wire logic [3:0]  portCOut,
  input wire logic [3:0]  portCOe
);
  logic [3:0] idle;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Cycles since srcClk last moved; no count clock may appear without it.
  always_ff @(posedge sys_clk)
    if (rst || srcClk != $past(srcClk))
      idle <= 4'h0;
    else if (idle != 4'hF)
      idle <= idle + 4'h1;
  oe_unused_a:
    assert property (portBOe[7:5] == 3'h0 && portBOe[3:1] == 3'h0 && portCOe[3:1] == 3'h0)
    else $error("input pin driven");
  out_unused_a:
    assert property (portBOut[7:5] == 3'h0 && portBOut[3:1] == 3'h0 && portCOut[3:1] == 3'h0)
    else $error("input pin carries data");
  reset_clear_a:
    assert property ($fell(rst) |-> portBOut == 8'h00 && portCOut == 4'h0 && portBOe == 8'h00)
    else $error("pins not cleared by reset");
  ready_now_a:
    assert property (psel && penable |-> pready)
    else $error("access not answered");
  unmapped_err_a:
    assert property (psel && penable && paddr > 8'h0C |-> pslverr)
    else $error("unmapped access accepted");
  mapped_ok_a:
    assert property (psel && penable && paddr <= 8'h0C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a:
    assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
  src_still_a:
    assert property (idle >= 4'hA && !psel && !$past(psel) && !$past(psel, 2)
                     |-> $stable({portBOut[4], portBOut[0], portCOut[0]}))
    else $error("wave moved without source clock");
endmodule
bind tsrc_top tsrc_props chk
(
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .srcClk(srcClk), .portBOut(portBOut), .portBOe(portBOe),
  .portCOut(portCOut), .portCOe(portCOe)
);
`default_nettype wire

// ---- tsrc_rate_sink.sv ----
// Serial controller side: times the levels of one rate clock.
// Assumes it samples the clock on sys_clk like a synchronous receiver.
`timescale 1ns/100ps
`default_nettype none
module tsrc_rate_sink
(
  // Clock
  input wire logic sys_clk,
  // Rate clock
  input wire logic rateClk,
  // Last level length and edge count
  output int       halfLen,
  output int       edges
);
  int   run = 0;
  logic last = 1'b0;
  // An unknown level before reset reads as low, so no false edge is counted.
  wire  logic lvl = (rateClk === 1'b1);
  // A short level would garble a received bit, so each one is timed.
  always @(posedge sys_clk)
  begin
    run <= (lvl != last) ? 1 : run + 1;
    if (lvl != last)
    begin
      halfLen <= run;
      edges <= edges + 1;
    end
    last <= lvl;
  end
  initial edges = 0;
endmodule
`default_nettype wire

// ---- tb_triple_square_wave_rate_clock.sv ----
// Bench for the rate clock block: APB host, source clock, three sinks.
// Assumes zero-wait APB; srcClk runs at a quarter of sys_clk.
`timescale 1ns/100ps
`default_nettype none
module tb_triple_square_wave_rate_clock;
  import tsrc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        srcClk = 1'b0;
  logic        srcRun = 1'b1;
  logic        err, pready, pslverr, held;
  logic [1:0]  ph = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [7:0]  portBOut, portBOe;
  logic [3:0]  portCOut, portCOe;
  logic [31:0] pwdata = 32'h0, prdata, rdv, cnt;
  logic [31:0] lfsr = 32'hCB8D91F7;
  wire  logic [2:0] w = {portCOut[0], portBOut[0], portBOut[4]};
  int          num_errors = 0;
  int          n_checks = 0;
  int          halfLen[3], edges[3], tc[3], n;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("[ERR] %0t mismatch", $time); end end
  // Clock at 25 MHz.
  always #20 sys_clk = ~sys_clk;
  // The source toggles every two cycles, below half the sampling rate.
  always @(posedge sys_clk)
  begin
    ph <= ph + 2'h1;
    if (srcRun && ph[0])
      srcClk <= ~srcClk;
  end
  tsrc_top dut
  (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .srcClk(srcClk),
    .portBOut(portBOut), .portBOe(portBOe), .portCOut(portCOut), .portCOe(portCOe)
  );
  for (genvar g = 0; g < 3; g++)
  begin : g_snk
    tsrc_rate_sink snk (.sys_clk(sys_clk), .rateClk(w[g]), .halfLen(halfLen[g]), .edges(edges[g]));
  end
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Every open-ended wait goes through here, so a hang ends the run.
  task automatic step(inout int k);
    @(posedge sys_clk);
    k++;
    if (k > 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      step(k);
    while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Random source for the stimulus, a plain shift register with feedback.
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, TSRC_OFF_CTRL, {24'h0, idx});
    apb(1'b1, TSRC_OFF_CTRL, {24'h0, v});
  endtask
  task automatic rreg(input logic [7:0] idx);
    apb(1'b1, TSRC_OFF_CTRL, {24'h0, idx});
    apb(1'b0, TSRC_OFF_CTRL, 32'h0);
  endtask
  task automatic waitEdges(input int ch, input int e);
    int k;
    k = 0;
    while (edges[ch] < e)
      step(k);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, TSRC_OFF_STATUS, 32'h0);
    `CHK(rdv[9:8], 2'h1)
    `CHK(err, 1'b0)
    apb(1'b1, TSRC_OFF_PTR, {26'h0, TSRC_IDX_MODE0});
    apb(1'b1, TSRC_OFF_DATA, 32'hC2);
    wreg(8'h00, 8'h00);
    apb(1'b1, TSRC_OFF_CTRL, {26'h0, TSRC_IDX_MODE0});
    apb(1'b0, TSRC_OFF_STATUS, 32'h0);
    `CHK(rdv[9:8], 2'h2)
    apb(1'b0, TSRC_OFF_CTRL, 32'h0);
    `CHK(rdv[7:0], TSRC_MODE_RESET)
    apb(1'b0, TSRC_OFF_STATUS, 32'h0);
    `CHK(rdv[9], 1'b0)
    // Random constants, then continuous square wave with output enabled, then gate and trigger.
    for (int i = 0; i < 3; i++)
    begin
      lfsr = nextRand(lfsr);
      tc[i] = 2 + int'(lfsr[1:0]);
      wreg(8'(TSRC_IDX_TCMSB0 + 2 * i), 8'h00);
      wreg(8'(TSRC_IDX_TCMSB0 + 2 * i + 1), 8'(tc[i]));
      wreg(8'(TSRC_IDX_MODE0 + i), 8'hC2);
      wreg(8'(TSRC_IDX_CMD0 + i), 8'h06);
    end
    `CHK({portCOe[0], portBOe[0], portBOe[4]}, 3'h7)
    // A count clock is eight cycles here, and each level lasts tc of them.
    for (int i = 0; i < 3; i++)
    begin
      waitEdges(i, 6);
      `CHK(halfLen[i], 8 * tc[i])
    end
    srcRun <= 1'b0;
    repeat (12) @(posedge sys_clk);
    n = edges[0] + edges[1] + edges[2];
    repeat (30) @(posedge sys_clk);
    `CHK(edges[0] + edges[1] + edges[2], n)
    srcRun <= 1'b1;
    wreg(TSRC_IDX_CMD0, 8'h00);
    held = portBOut[4];
    rreg(8'(TSRC_IDX_TCMSB0 + 1));
    cnt = rdv;
    repeat (40) @(posedge sys_clk);
    `CHK(portBOut[4], held)
    rreg(8'(TSRC_IDX_TCMSB0 + 1));
    `CHK(rdv[7:0], cnt[7:0])
    n = edges[0];
    wreg(TSRC_IDX_CMD0, 8'h04);
    waitEdges(0, n + 2);
    `CHK(halfLen[0], 8 * tc[0])
    apb(1'b1, 8'h10, 32'hFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(err, 1'b1)
    tally_and_finish();
  end
endmodule
`default_nettype wire
